//--- tdr_regs.sv
// module: draw_command_code set, line colour and colour-limit register bank with launch logic
//
// Function
// - autoexecute 0 launches on command write; 1 launches on last set register write.
// - autoexecute line launches on scan-line count write, triangle on final y write.
// - clip limits apply only while the hardware clip bit is set.
// - destination format 000 palettized, 001 1555, 010 888; others reserved.
// - texel format codes 8888,4444,1555,a4b4,b4 low,b4 high,palettized,111 video.
// - mipmap size field holds log2 of side; values above 9 disallowed.
// - filter codes as listed; 101 only with video texels; 111 reserved.
// - texture blend 00 reflection, 01 modulate, 10 decal, 11 reserved.
// - fog enable bit; no fog for gouraud or source alpha blending.
// - alpha blend 00/01 off, 10 texture alpha, 11 source alpha.
// - depth compare codes never through always, in listed order.
// - depth write only when enabled and compare passes.
// - depth mode 00 normal, 01 z pass, 10 draw pass, 11 reserved.
// - texture wrap enable bit; border colour used when clear.
// - command codes gouraud, lit, unlit, perspective variants, line, nop.
// - top bit shows 3d while a draw_command_code runs, else 0.
// - delta registers pack two signed s8.7 increments per word.
// - colour limit gives blend end colour: bytes low/blue, high/green, red.
`timescale 1ns/1ps

module tdr_regs (
  // clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    resetn_i,
  // register port
  input  wire logic [15:0]             addr_i,
  input  wire logic [31:0]             wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [31:0]             rdata_o,
  // render engine handshake
  input  wire logic                    engine_done_i,
  output logic                         launch_o,
  output logic      [3:0]              launch_cmd_o,
  output logic                         busy_3d_o,
  // decoded controls and attributes
  output tdr_pkg::tdr_ctl_s            ctl_o,
  output tdr_pkg::tdr_cmd_s            cmd_o,
  output tdr_pkg::tdr_pair_s           gb_delta_o,
  output tdr_pkg::tdr_pair_s           ar_delta_o,
  output tdr_pkg::tdr_pair_s           gb_start_o,
  output tdr_pkg::tdr_pair_s           ar_start_o,
  output tdr_pkg::tdr_climb_s          color_limit_o,
  output logic      [10:0]             ycnt_o,
  // depth pipeline
  input  wire logic                    zpass_i,
  output logic                         zwrite_o,
  // software misuse flag
  output logic                         cfg_illegal_o
);

  // ==========================================================================
  // storage
  tdr_pkg::tdr_cmd_s   cmd_r;
  tdr_pkg::tdr_pair_s  gbd_r, ard_r, gbs_r, ars_r;
  tdr_pkg::tdr_climb_s climb_r;
  logic [10:0]         ycnt_r;
  logic                busy_r;
  logic                wr_cmd, wr_ycnt, wr_fy, go;
  logic [3:0]          cmd_code;
  logic                illegal_nxt;

  assign wr_cmd  = wr_i && (addr_i == tdr_pkg::OFS_LINE_CMD || addr_i == tdr_pkg::OFS_TRI_CMD);
  assign wr_ycnt = wr_i && addr_i == tdr_pkg::OFS_LINE_YCNT;
  assign wr_fy   = wr_i && addr_i == tdr_pkg::OFS_TRI_FINALY;

  // ==========================================================================
  // command set register; top bit is status, not stored from software
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cmd_r <= tdr_pkg::tdr_cmd_s'(tdr_pkg::RST_WORD);
      cmd_r.draw_command_code <= tdr_pkg::RST_CMD_CODE;
    end else if (wr_cmd) begin
      cmd_r <= tdr_pkg::tdr_cmd_s'(wdata_i);
      cmd_r.dimension_indicator <= 1'b0;
    end
  end

  // ==========================================================================
  // line colour attribute and colour limit registers
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      gbd_r   <= tdr_pkg::RST_WORD;
      ard_r   <= tdr_pkg::RST_WORD;
      gbs_r   <= tdr_pkg::RST_WORD;
      ars_r   <= tdr_pkg::RST_WORD;
      climb_r <= tdr_pkg::RST_WORD[tdr_pkg::CLIMB_W-1:0];
      ycnt_r  <= tdr_pkg::RST_WORD[tdr_pkg::YCNT_W-1:0];
    end else if (wr_i) begin
      case (addr_i)
        tdr_pkg::OFS_LINE_GB_DL: gbd_r <= wdata_i;
        tdr_pkg::OFS_LINE_AR_DL: ard_r <= wdata_i;
        tdr_pkg::OFS_LINE_GB_ST: gbs_r <= wdata_i;
        tdr_pkg::OFS_LINE_AR_ST: ars_r <= wdata_i;
        tdr_pkg::OFS_COLOR_LIMB: climb_r <= wdata_i[tdr_pkg::CLIMB_W-1:0];
        tdr_pkg::OFS_LINE_YCNT:  ycnt_r <= wdata_i[tdr_pkg::YCNT_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // launch decision; the command code comes from the word being written
  // so a direct-mode launch uses the new command without an extra cycle
  always_comb begin
    cmd_code = cmd_r.draw_command_code;
    go       = 1'b0;
    if (wr_cmd) begin
      cmd_code = wdata_i[30:27];
      go = !wdata_i[0] && wdata_i[30:27] != tdr_pkg::CMD_NOP;
    end else if (cmd_r.auto_execute && cmd_r.draw_command_code != tdr_pkg::CMD_NOP) begin
      // only the drawing set that matches the command launches it
      if (cmd_r.draw_command_code == tdr_pkg::CMD_LINE) begin
        go = wr_ycnt;
      end else begin
        go = wr_fy;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      launch_o     <= 1'b0;
      launch_cmd_o <= tdr_pkg::RST_CMD_CODE;
    end else begin
      launch_o     <= go;
      launch_cmd_o <= cmd_code;
    end
  end

  // a new launch wins over a done in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      busy_r <= 1'b0;
    end else if (go) begin
      busy_r <= 1'b1;
    end else if (engine_done_i) begin
      busy_r <= 1'b0;
    end
  end
  assign busy_3d_o = busy_r;

  // ==========================================================================
  // decoded controls, registered
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctl_o <= '0;
    end else begin
      ctl_o.clip_active    <= cmd_r.hw_clip_enable;
      // fog suppressed where unsupported rather than trusting software
      ctl_o.fog_active     <= cmd_r.fog_on && cmd_r.draw_command_code != tdr_pkg::CMD_GOURAUD
                              && cmd_r.alpha_blend_ctl != tdr_pkg::AB_SRC;
      ctl_o.alpha_blend_on <= cmd_r.alpha_blend_ctl[1];
      ctl_o.alpha_from_src <= cmd_r.alpha_blend_ctl == tdr_pkg::AB_SRC;
      ctl_o.depth_write    <= cmd_r.depth_write_enable;
      ctl_o.depth_test     <= cmd_r.depth_test_select;
      ctl_o.depth_mode     <= cmd_r.depth_buffering_select;
      ctl_o.wrap_on        <= cmd_r.texture_wrap_on;
      ctl_o.four_bit_blend_texel <= cmd_r.texel_pixel_format == tdr_pkg::TEX_B4_LO
                                 || cmd_r.texel_pixel_format == tdr_pkg::TEX_B4_HI;
      ctl_o.video_two_tap_filter <= cmd_r.texel_filter_select == tdr_pkg::FLT_VIDEO
                                 && cmd_r.texel_pixel_format == tdr_pkg::TEX_VIDEO;
      ctl_o.bilinear_filter      <= cmd_r.texel_filter_select == 3'h6;
      ctl_o.nearest_mip_filter   <= cmd_r.texel_filter_select == 3'h0;
      // size clamps at the largest legal side
      ctl_o.mip_side <= (cmd_r.mip_size_log2 > tdr_pkg::MIP_MAX) ? 10'h200
                        : 10'(10'h001 << cmd_r.mip_size_log2);
    end
  end

  // depth write gate; depth mode 11 reserved, treated as no write
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      zwrite_o <= 1'b0;
    end else begin
      zwrite_o <= cmd_r.depth_write_enable && zpass_i
                  && cmd_r.depth_buffering_select != tdr_pkg::ZM_RSVD;
    end
  end

  // reserved or forbidden combinations flagged for software debug
  always_comb begin
    illegal_nxt = 1'b0;
    if (cmd_r.target_pixel_format > tdr_pkg::FMT_RGB888) illegal_nxt = 1'b1;
    if (cmd_r.mip_size_log2 > tdr_pkg::MIP_MAX) illegal_nxt = 1'b1;
    if (cmd_r.texel_filter_select == tdr_pkg::FLT_RSVD) illegal_nxt = 1'b1;
    if (cmd_r.texel_filter_select == tdr_pkg::FLT_VIDEO
        && cmd_r.texel_pixel_format != tdr_pkg::TEX_VIDEO) illegal_nxt = 1'b1;
    if (cmd_r.texel_pixel_format == tdr_pkg::TEX_PAL8
        && ((cmd_r.texel_filter_select != 3'h0 && cmd_r.texel_filter_select != 3'h4)
            || cmd_r.texture_blend_select != 2'h2)) illegal_nxt = 1'b1;
    if (cmd_r.texture_blend_select == tdr_pkg::TB_RSVD) illegal_nxt = 1'b1;
    if (cmd_r.depth_buffering_select == tdr_pkg::ZM_RSVD) illegal_nxt = 1'b1;
    if (cmd_r.fog_on && (cmd_r.draw_command_code == tdr_pkg::CMD_GOURAUD
        || cmd_r.alpha_blend_ctl == tdr_pkg::AB_SRC)) illegal_nxt = 1'b1;
    if (gbs_r.lo[15] || gbs_r.hi[15] || ars_r.lo[15] || ars_r.hi[15]) illegal_nxt = 1'b1;
    // texel mode taken from the live command word, not the registered decode,
    // so this check lines up in time with the others
    if (cmd_r.target_pixel_format == tdr_pkg::FMT_PAL8
        && (cmd_r.texel_pixel_format == tdr_pkg::TEX_B4_LO
            || cmd_r.texel_pixel_format == tdr_pkg::TEX_B4_HI)
        && climb_r.lo_blue != climb_r.hi_green) illegal_nxt = 1'b1;
    case (cmd_r.draw_command_code)
      tdr_pkg::CMD_GOURAUD, tdr_pkg::CMD_LIT_TEX, tdr_pkg::CMD_UNLIT_TEX,
      tdr_pkg::CMD_LIT_PERSP, tdr_pkg::CMD_UNLIT_PSP, tdr_pkg::CMD_LINE,
      tdr_pkg::CMD_NOP: ;
      default: illegal_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cfg_illegal_o <= 1'b0;
    end else begin
      cfg_illegal_o <= illegal_nxt;
    end
  end

  // ==========================================================================
  // attribute outputs, registered copies
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cmd_o         <= tdr_pkg::tdr_cmd_s'(tdr_pkg::RST_WORD);
      gb_delta_o    <= tdr_pkg::RST_WORD;
      ar_delta_o    <= tdr_pkg::RST_WORD;
      gb_start_o    <= tdr_pkg::RST_WORD;
      ar_start_o    <= tdr_pkg::RST_WORD;
      color_limit_o <= tdr_pkg::RST_WORD[tdr_pkg::CLIMB_W-1:0];
      ycnt_o        <= tdr_pkg::RST_WORD[tdr_pkg::YCNT_W-1:0];
    end else begin
      cmd_o         <= cmd_r;
      gb_delta_o    <= gbd_r;
      ar_delta_o    <= ard_r;
      gb_start_o    <= gbs_r;
      ar_start_o    <= ars_r;
      color_limit_o <= climb_r;
      ycnt_o        <= ycnt_r;
    end
  end

  // ==========================================================================
  // read port; unmapped reads return zero
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_o <= tdr_pkg::RST_WORD;
    end else if (rd_i) begin
      case (addr_i)
        tdr_pkg::OFS_LINE_CMD,
        tdr_pkg::OFS_TRI_CMD:    rdata_o <= {busy_r, cmd_r[30:0]};
        tdr_pkg::OFS_LINE_GB_DL: rdata_o <= gbd_r;
        tdr_pkg::OFS_LINE_AR_DL: rdata_o <= ard_r;
        tdr_pkg::OFS_LINE_GB_ST: rdata_o <= gbs_r;
        tdr_pkg::OFS_LINE_AR_ST: rdata_o <= ars_r;
        tdr_pkg::OFS_COLOR_LIMB: rdata_o <= {8'h00, climb_r};
        tdr_pkg::OFS_LINE_YCNT:  rdata_o <= {21'h0, ycnt_r};
        tdr_pkg::OFS_STATUS:     rdata_o <= {30'h0, cfg_illegal_o, busy_r};
        default:                 rdata_o <= tdr_pkg::RST_WORD;
      endcase
    end else begin
      rdata_o <= tdr_pkg::RST_WORD;
    end
  end

  // ==========================================================================
  // checks
  property p_direct_launch;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (wr_cmd && !wdata_i[0] && wdata_i[30:27] != tdr_pkg::CMD_NOP) |=> launch_o;
  endproperty
  a_direct_launch: assert property (p_direct_launch) else $error("no launch on cmd write");

  property p_nop_quiet;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (wr_cmd && wdata_i[30:27] == tdr_pkg::CMD_NOP) |=> !launch_o;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("nop write launched");

  property p_auto_hold;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (wr_cmd && wdata_i[0]) |=> !launch_o;
  endproperty
  a_auto_hold: assert property (p_auto_hold) else $error("auto mode launched on cmd write");

  property p_line_auto;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (cmd_r.auto_execute && cmd_r.draw_command_code == tdr_pkg::CMD_LINE && wr_ycnt && !wr_cmd)
      |=> launch_o && launch_cmd_o == tdr_pkg::CMD_LINE;
  endproperty
  a_line_auto: assert property (p_line_auto) else $error("line autoexecute missed");

  property p_tri_auto;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (cmd_r.auto_execute && cmd_r.draw_command_code != tdr_pkg::CMD_LINE
       && cmd_r.draw_command_code != tdr_pkg::CMD_NOP && wr_fy && !wr_cmd) |=> launch_o;
  endproperty
  a_tri_auto: assert property (p_tri_auto) else $error("triangle autoexecute missed");

  property p_busy_set;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      launch_o |-> busy_r;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set by launch");

  property p_zwrite;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      zwrite_o |-> $past(zpass_i) && $past(cmd_r.depth_write_enable);
  endproperty
  a_zwrite: assert property (p_zwrite) else $error("depth written without pass");

  property p_clip;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      ##1 ctl_o.clip_active == $past(cmd_r.hw_clip_enable);
  endproperty
  a_clip: assert property (p_clip) else $error("clip enable mismatch");

  property p_fog_off;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      ctl_o.fog_active |-> $past(cmd_r.alpha_blend_ctl) != tdr_pkg::AB_SRC;
  endproperty
  a_fog_off: assert property (p_fog_off) else $error("fog with source alpha");

  property p_read_lat;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (rd_i && addr_i == tdr_pkg::OFS_LINE_GB_DL) |=> rdata_o == $past(gbd_r);
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("delta readback wrong");

  property p_busy_clear;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (engine_done_i && !go) |=> !busy_r;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared by done");

  property p_dim_read;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (rd_i && addr_i == tdr_pkg::OFS_TRI_CMD) |=> rdata_o[31] == $past(busy_r);
  endproperty
  a_dim_read: assert property (p_dim_read) else $error("dimension bit wrong");

  property p_rsvd_blend;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (cmd_r.texture_blend_select == tdr_pkg::TB_RSVD) |=> cfg_illegal_o;
  endproperty
  a_rsvd_blend: assert property (p_rsvd_blend) else $error("reserved blend not flagged");

  property p_depth_mode;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      ##1 ctl_o.depth_mode == $past(cmd_r.depth_buffering_select);
  endproperty
  a_depth_mode: assert property (p_depth_mode) else $error("depth mode mismatch");

  property p_video_tap;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      ctl_o.video_two_tap_filter |-> $past(cmd_r.texel_pixel_format) == tdr_pkg::TEX_VIDEO;
  endproperty
  a_video_tap: assert property (p_video_tap) else $error("video tap on wrong texels");

  c_direct: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) wr_cmd ##1 launch_o);
  c_line:   cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
                            cmd_r.auto_execute && wr_ycnt ##1 launch_o);
  c_tri:    cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
                            cmd_r.auto_execute && wr_fy ##1 launch_o);
  c_done:   cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
                            busy_r ##1 engine_done_i ##1 !busy_r);

endmodule

//--- tdr_pkg.sv
// package: register map, command set fields and codes for the draw_command_code register bank
package tdr_pkg;

  // =========================================================================
  // register byte offsets
  localparam logic [15:0] OFS_LINE_CMD   = 16'hB100;
  localparam logic [15:0] OFS_LINE_GB_DL = 16'hB144;
  localparam logic [15:0] OFS_LINE_AR_DL = 16'hB148;
  localparam logic [15:0] OFS_LINE_GB_ST = 16'hB14C;
  localparam logic [15:0] OFS_LINE_AR_ST = 16'hB150;
  localparam logic [15:0] OFS_LINE_YCNT  = 16'hB17C;
  localparam logic [15:0] OFS_COLOR_LIMB = 16'hB4FC;
  localparam logic [15:0] OFS_TRI_CMD    = 16'hB500;
  localparam logic [15:0] OFS_TRI_FINALY = 16'hB57C;
  localparam logic [15:0] OFS_STATUS     = 16'hB580;

  // =========================================================================
  // reset values (power-on contents undefined, zero chosen, command code F for nop)
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic [3:0]  RST_CMD_CODE   = 4'hF;

  // =========================================================================
  // field widths
  localparam int unsigned CLIMB_W = 24;
  localparam int unsigned YCNT_W  = 11;

  // =========================================================================
  // command codes
  localparam logic [3:0] CMD_GOURAUD   = 4'h0;
  localparam logic [3:0] CMD_LIT_TEX   = 4'h1;
  localparam logic [3:0] CMD_UNLIT_TEX = 4'h2;
  localparam logic [3:0] CMD_LIT_PERSP = 4'h5;
  localparam logic [3:0] CMD_UNLIT_PSP = 4'h6;
  localparam logic [3:0] CMD_LINE      = 4'h8;
  localparam logic [3:0] CMD_NOP       = 4'hF;

  // =========================================================================
  // field codes
  localparam logic [2:0] FMT_PAL8      = 3'h0;
  localparam logic [2:0] FMT_RGB1555   = 3'h1;
  localparam logic [2:0] FMT_RGB888    = 3'h2;
  localparam logic [2:0] TEX_B4_LO     = 3'h4;
  localparam logic [2:0] TEX_B4_HI     = 3'h5;
  localparam logic [2:0] TEX_PAL8      = 3'h6;
  localparam logic [2:0] TEX_VIDEO     = 3'h7;
  localparam logic [3:0] MIP_MAX       = 4'h9;
  localparam logic [2:0] FLT_VIDEO     = 3'h5;
  localparam logic [2:0] FLT_RSVD      = 3'h7;
  localparam logic [1:0] TB_RSVD       = 2'h3;
  localparam logic [1:0] ZM_RSVD       = 2'h3;
  localparam logic [1:0] AB_TEX        = 2'h2;
  localparam logic [1:0] AB_SRC        = 2'h3;

  // =========================================================================
  // command set word layout, msb first
  typedef struct packed {
    logic       dimension_indicator;
    logic [3:0] draw_command_code;
    logic       texture_wrap_on;
    logic [1:0] depth_buffering_select;
    logic       depth_write_enable;
    logic [2:0] depth_test_select;
    logic [1:0] alpha_blend_ctl;
    logic       fog_on;
    logic [1:0] texture_blend_select;
    logic [2:0] texel_filter_select;
    logic [3:0] mip_size_log2;
    logic [2:0] texel_pixel_format;
    logic [2:0] target_pixel_format;
    logic       hw_clip_enable;
    logic       auto_execute;
  } tdr_cmd_s;

  // two s8.7 values in one word
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } tdr_pair_s;

  // interpolation end colour
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] hi_green;
    logic [7:0] lo_blue;
  } tdr_climb_s;

  // decoded controls towards the render datapath
  typedef struct packed {
    logic       clip_active;
    logic       fog_active;
    logic       alpha_blend_on;
    logic       alpha_from_src;
    logic       depth_write;
    logic [2:0] depth_test;
    logic [1:0] depth_mode;
    logic       wrap_on;
    logic       four_bit_blend_texel;
    logic       video_two_tap_filter;
    logic       bilinear_filter;
    logic       nearest_mip_filter;
    logic [9:0] mip_side;
  } tdr_ctl_s;

endpackage

//--- tdr_testbench.sv
// testbench: self-checking random and corner-case run of the draw_command_code register bank
`timescale 1ns/1ps

module testbench;
  // ==========================================================================
  // stimulus and observation signals
  localparam logic [31:0] LEGAL = 32'h0CF0_8405;
  localparam logic [15:0] PAIR_OFS [4] = '{tdr_pkg::OFS_LINE_GB_DL, tdr_pkg::OFS_LINE_AR_DL,
                                           tdr_pkg::OFS_LINE_GB_ST, tdr_pkg::OFS_LINE_AR_ST};
  localparam logic [31:0] BAD [8] = '{32'h0CF0_840D, 32'h0CF0_8A05, 32'h0CF0_F405,
                                      32'h0CF1_8405, 32'h0FF0_8405, 32'h0CF0_94C5,
                                      32'h0CFE_8405, 32'h1CF0_8405};
  localparam logic [3:0]  CODES [6] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h8};
  logic                   ref_clk_i;
  logic                   resetn_i;
  logic [15:0]            addr_i;
  logic [31:0]            wdata_i;
  logic                   wr_i;
  logic                   rd_i;
  logic [31:0]            rdata_o;
  logic                   engine_done_i;
  logic                   launch_o;
  logic [3:0]             launch_cmd_o;
  logic                   busy_3d_o;
  tdr_pkg::tdr_ctl_s      ctl_o;
  tdr_pkg::tdr_cmd_s      cmd_o;
  tdr_pkg::tdr_pair_s     gb_delta_o;
  tdr_pkg::tdr_pair_s     ar_delta_o;
  tdr_pkg::tdr_pair_s     gb_start_o;
  tdr_pkg::tdr_pair_s     ar_start_o;
  tdr_pkg::tdr_climb_s    color_limit_o;
  logic [10:0]            ycnt_o;
  logic                   zpass_i;
  logic                   zwrite_o;
  logic                   cfg_illegal_o;
  int                     n_mismatch;
  int                     checked;

  tdr_regs i_tdr_regs (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .engine_done_i(engine_done_i),
    .launch_o(launch_o), .launch_cmd_o(launch_cmd_o), .busy_3d_o(busy_3d_o),
    .ctl_o(ctl_o), .cmd_o(cmd_o), .gb_delta_o(gb_delta_o), .ar_delta_o(ar_delta_o),
    .gb_start_o(gb_start_o), .ar_start_o(ar_start_o), .color_limit_o(color_limit_o),
    .ycnt_o(ycnt_o), .zpass_i(zpass_i), .zwrite_o(zwrite_o), .cfg_illegal_o(cfg_illegal_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================================
  // helpers
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // the done pulse is sent only after busy was seen, so launch never races it
  task automatic launch_chk(input logic [15:0] a, input logic [31:0] d, input logic exp_l,
                            input logic [3:0] code);
    logic [31:0] r;
    wr_reg(a, d);
    chk(launch_o, exp_l, "launch pulse");
    if (exp_l) begin
      chk(launch_cmd_o, code, "launch code");
      rd_reg(tdr_pkg::OFS_LINE_CMD, r);
      chk(r[31], 1'b1, "dimension while running");
      chk(busy_3d_o, 1'b1, "busy while running");
      @(posedge ref_clk_i);
      engine_done_i <= 1'b1;
      @(posedge ref_clk_i);
      engine_done_i <= 1'b0;
      #1;
      chk(busy_3d_o, 1'b0, "idle after done");
    end
  endtask

  function automatic logic [31:0] cmd_word(input logic [3:0] code, input logic auto);
    return (LEGAL & 32'h87FF_FFFE) | {1'b0, code, 26'h0, auto};
  endfunction

  function automatic logic [9:0] exp_mip(input logic [3:0] s);
    return (s > 4'h9) ? 10'h200 : 10'(1 << s);
  endfunction

  function automatic logic [31:0] pair_port(input int unsigned k);
    case (k)
      0:       return gb_delta_o;
      1:       return ar_delta_o;
      2:       return gb_start_o;
      default: return ar_start_o;
    endcase
  endfunction

  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [31:0] w;
    logic [10:0] y;
    logic        zp;
    resetn_i      = 1'b0;
    addr_i        = 16'h0000;
    wdata_i       = 32'h0000_0000;
    wr_i          = 1'b0;
    rd_i          = 1'b0;
    engine_done_i = 1'b0;
    zpass_i       = 1'b0;
    n_mismatch    = 0;
    checked       = 0;
    void'($urandom(32'hDA13FE13));
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd_reg(tdr_pkg::OFS_LINE_CMD, d);
    chk(d, 32'h7800_0000, "command after reset");
    wr_reg(16'hB104, $urandom());
    rd_reg(16'hB104, d);
    chk(d, 32'h0000_0000, "unmapped read");
    for (int k = 0; k < 4; k++) begin
      w = (k < 2) ? $urandom() : ($urandom() & 32'h7FFF_7FFF);
      wr_reg(PAIR_OFS[k], w);
      rd_reg(PAIR_OFS[k], d);
      chk(d, w, "pair readback");
      chk(pair_port(k), w, "pair port halves");
    end
    w = $urandom();
    w[15:8] = w[7:0];
    wr_reg(tdr_pkg::OFS_COLOR_LIMB, w);
    rd_reg(tdr_pkg::OFS_COLOR_LIMB, d);
    chk(d[23:0], w[23:0], "limit readback");
    chk(color_limit_o, w[23:0], "limit port bytes");
    for (int k = 0; k < 12; k++) begin
      w = $urandom() | 32'h0000_0001;
      zp = 1'($urandom());
      @(posedge ref_clk_i);
      zpass_i <= zp;
      wr_reg((k % 2) ? tdr_pkg::OFS_TRI_CMD : tdr_pkg::OFS_LINE_CMD, w);
      chk(launch_o, 1'b0, "no launch in auto mode");
      rd_reg(tdr_pkg::OFS_LINE_CMD, d);
      chk(d, {1'b0, w[30:0]}, "command readback");
      chk(cmd_o, {1'b0, w[30:0]}, "command fields");
      chk(ctl_o.clip_active, w[1], "clip gate");
      chk(ctl_o.mip_side, exp_mip(w[11:8]), "mip side");
      chk(ctl_o.four_bit_blend_texel, w[7:6] == 2'b10, "four_bit_blend_texel texel");
      chk(ctl_o.nearest_mip_filter, w[14:12] == 3'h0, "nearest mip");
      chk(ctl_o.bilinear_filter, w[14:12] == 3'h6, "bilinear");
      chk(ctl_o.video_two_tap_filter, w[14:12] == 3'h5 && w[7:5] == 3'h7, "video tap");
      chk(ctl_o.alpha_blend_on, w[19], "alpha on");
      chk(ctl_o.alpha_from_src, w[19:18] == tdr_pkg::AB_SRC, "alpha source");
      chk(ctl_o.fog_active, w[17] && w[30:27] != tdr_pkg::CMD_GOURAUD
          && w[19:18] != tdr_pkg::AB_SRC, "fog gate");
      chk(ctl_o.depth_test, w[22:20], "depth test");
      chk(ctl_o.depth_mode, w[25:24], "depth mode");
      chk(ctl_o.wrap_on, w[26], "wrap");
      chk(zwrite_o, w[23] && zp && w[25:24] != tdr_pkg::ZM_RSVD, "depth write");
    end
    wr_reg(tdr_pkg::OFS_TRI_CMD, LEGAL);
    rd_reg(tdr_pkg::OFS_STATUS, d);
    chk(d[1], 1'b0, "legal setting");
    for (int k = 0; k < 8; k++) begin
      wr_reg(tdr_pkg::OFS_TRI_CMD, BAD[k]);
      rd_reg(tdr_pkg::OFS_STATUS, d);
      chk(d[1], 1'b1, "reserved setting flagged");
      chk(cfg_illegal_o, 1'b1, "misuse flag");
    end
    for (int k = 0; k < 6; k++) begin
      launch_chk((CODES[k] == tdr_pkg::CMD_LINE) ? tdr_pkg::OFS_LINE_CMD : tdr_pkg::OFS_TRI_CMD,
                 cmd_word(CODES[k], 1'b0), 1'b1, CODES[k]);
    end
    launch_chk(tdr_pkg::OFS_TRI_CMD, cmd_word(tdr_pkg::CMD_NOP, 1'b0), 1'b0, 4'hF);
    launch_chk(tdr_pkg::OFS_LINE_CMD, cmd_word(tdr_pkg::CMD_LINE, 1'b1), 1'b0, 4'h8);
    for (int k = 0; k < 2; k++) begin
      y = 11'($urandom());
      launch_chk(tdr_pkg::OFS_LINE_YCNT, {21'h0, y}, 1'b1, tdr_pkg::CMD_LINE);
      chk(ycnt_o, y, "scan-line count");
    end
    launch_chk(tdr_pkg::OFS_TRI_CMD, cmd_word(tdr_pkg::CMD_LIT_PERSP, 1'b1), 1'b0, 4'h5);
    launch_chk(tdr_pkg::OFS_TRI_FINALY, $urandom(), 1'b1, tdr_pkg::CMD_LIT_PERSP);
    launch_chk(tdr_pkg::OFS_LINE_CMD, cmd_word(tdr_pkg::CMD_NOP, 1'b0), 1'b0, 4'hF);
    launch_chk(tdr_pkg::OFS_TRI_FINALY, $urandom(), 1'b0, 4'hF);
    launch_chk(tdr_pkg::OFS_LINE_YCNT, 32'h0000_0010, 1'b0, 4'hF);
    conclude();
  end
endmodule
